/* File: verilog/switch_input_status_regs.svh */
// Register offsets, reset values and field positions of the switch input status bank.
// Assumes it is included by bare name wherever these constants are used.
`ifndef SWITCH_INPUT_STATUS_REGS_SVH
`define SWITCH_INPUT_STATUS_REGS_SVH

`define SIS_ADDR_W 8
`define SIS_DATA_W 24
`define SIS_OFF_COMP_STATE 8'h05
`define SIS_OFF_ADC_STATE_LOW 8'h06
`define SIS_RST_COMP_STATE 24'h000000
`define SIS_RST_ADC_STATE_LOW 24'h000000
`define SIS_NUM_INPUTS 24
`define SIS_SINGLE_LAST 5'h0B
`define SIS_DUAL_FIRST 5'h0C
`define SIS_DUAL_LAST 5'h11
`define SIS_DUAL_BASE_BIT 5'h0C
`define SIS_CH_W 5

`endif

/* File: verilog/switch_status_pkg.sv */
// Types shared by the switch input status bank and its classifier.
// Assumes the constants header is compiled alongside.
`default_nettype none

package switch_status_pkg;

	// Zone of an input against a pair of thresholds; code 3 is never produced
	typedef enum logic [1:0] {
		ZONE_BELOW_LOW = 2'h0,
		ZONE_BETWEEN = 2'h1,
		ZONE_ABOVE_HIGH = 2'h2
	} zone_t;

endpackage : switch_status_pkg

`default_nettype wire

/* File: verilog/zone_classifier.sv */
// Classifies one ADC sample against a lower and an upper threshold.
// Assumes the upper threshold is not below the lower one.
`timescale 1ns/1ns
`default_nettype none

module zone_classifier #(
	parameter int ADC_W = 10
) (
	// Sample and thresholds
	input wire logic [ADC_W-1:0] value_i,
	input wire logic [ADC_W-1:0] thr_low_i,
	input wire logic [ADC_W-1:0] thr_high_i,
	// Result
	output switch_status_pkg::zone_t zone_o
);

	always_comb begin
		if (value_i >= thr_high_i) begin
			zone_o = switch_status_pkg::ZONE_ABOVE_HIGH;
		end else if (value_i >= thr_low_i) begin
			zone_o = switch_status_pkg::ZONE_BETWEEN;
		end else begin
			zone_o = switch_status_pkg::ZONE_BELOW_LOW;
		end
	end

endmodule : zone_classifier

`default_nettype wire

/* File: verilog/switch_input_status_regs.sv */
// Read-only status bank: comparator state and ADC threshold state of the switch inputs.
// Assumes the serial front end turns host frames into single-cycle read and write strobes,
// and the detection engine presents one-cycle sample strobes with their results.
//
// How it works
// - Offset 5h holds 24 comparator bits, reset zero, 1 means input above threshold.
// - Both status registers are read-only; host writes never change them.
// - Offset 6h, reset zero; bits 0-11 are 1 when ADC input exceeds its threshold.
// - Inputs 12-17 own two-bit fields, input 12 at 13-12 up to 17 at 23-22.
// - Field codes: 0 below lower, 1 between, 2 at or above upper; 3 unused.
`include "switch_input_status_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module switch_input_status_regs #(
	parameter int ADC_W = 10
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Register access from the serial front end
	input wire logic rd_en_i,
	input wire logic wr_en_i,
	input wire logic [`SIS_ADDR_W-1:0] addr_i,
	input wire logic [`SIS_DATA_W-1:0] wr_data_i,
	output logic [`SIS_DATA_W-1:0] rd_data_o,
	output logic rd_valid_o,
	// Comparator samples, one strobe per input
	input wire logic [`SIS_NUM_INPUTS-1:0] comp_sample_valid_i,
	input wire logic [`SIS_NUM_INPUTS-1:0] comp_above_i,
	// ADC samples, one channel at a time
	input wire logic adc_sample_valid_i,
	input wire logic [`SIS_CH_W-1:0] adc_channel_i,
	input wire logic [ADC_W-1:0] adc_value_i,
	// Programmed ADC thresholds
	input wire logic [ADC_W-1:0] adc_thr_single_i,
	input wire logic [ADC_W-1:0] adc_thr_low_i,
	input wire logic [ADC_W-1:0] adc_thr_high_i,
	// Live register contents
	output logic [`SIS_DATA_W-1:0] comp_state_o,
	output logic [`SIS_DATA_W-1:0] adc_state_o
);

	logic [`SIS_DATA_W-1:0] comp_input_state_r;
	logic [`SIS_DATA_W-1:0] adc_input_state_low_r;
	logic [`SIS_DATA_W-1:0] rd_data_nxt;
	logic [`SIS_DATA_W-1:0] rd_data_r;
	logic rd_valid_r;
	logic is_single_ch;
	logic is_dual_ch;
	logic single_above;
	logic [`SIS_CH_W-1:0] dual_pos;
	switch_status_pkg::zone_t dual_zone;

	assign is_single_ch = adc_channel_i <= `SIS_SINGLE_LAST;
	assign is_dual_ch = (adc_channel_i >= `SIS_DUAL_FIRST) && (adc_channel_i <= `SIS_DUAL_LAST);
	assign single_above = adc_value_i > adc_thr_single_i;
	// Low bit of the two-bit field of a dual-threshold channel
	assign dual_pos = `SIS_CH_W'((adc_channel_i - `SIS_DUAL_FIRST) << 1) + `SIS_DUAL_BASE_BIT;

	zone_classifier #(
		.ADC_W(ADC_W)
	) u_zone (
		.value_i(adc_value_i),
		.thr_low_i(adc_thr_low_i),
		.thr_high_i(adc_thr_high_i),
		.zone_o(dual_zone)
	);

	// Comparator state; write strobes have no path here
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			comp_input_state_r <= `SIS_RST_COMP_STATE;
		end else begin
			for (int n = 0; n < `SIS_NUM_INPUTS; n++) begin
				if (comp_sample_valid_i[n]) begin
					comp_input_state_r[n] <= comp_above_i[n];
				end
			end
		end
	end

	// ADC threshold state for inputs 0 to 17; other channels live elsewhere
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			adc_input_state_low_r <= `SIS_RST_ADC_STATE_LOW;
		end else if (adc_sample_valid_i) begin
			if (is_single_ch) begin
				adc_input_state_low_r[adc_channel_i] <= single_above;
			end else if (is_dual_ch) begin
				adc_input_state_low_r[dual_pos +: 2] <= dual_zone;
			end
		end
	end

	// Read decode; unmapped offsets read zero
	always_comb begin
		rd_data_nxt = '0;
		if (addr_i == `SIS_OFF_COMP_STATE) begin
			rd_data_nxt = comp_input_state_r;
		end else if (addr_i == `SIS_OFF_ADC_STATE_LOW) begin
			rd_data_nxt = adc_input_state_low_r;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rd_data_r <= '0;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= rd_en_i;
			if (rd_en_i) begin
				rd_data_r <= rd_data_nxt;
			end
		end
	end

	assign rd_data_o = rd_data_r;
	assign rd_valid_o = rd_valid_r;
	assign comp_state_o = comp_input_state_r;
	assign adc_state_o = adc_input_state_low_r;

	// Helper state for the checks below
	logic chk_dual_r;
	logic [`SIS_CH_W-1:0] chk_pos_r;
	logic [1:0] chk_zone_r;
	logic chk_single_r;
	logic [`SIS_CH_W-1:0] chk_ch_r;
	logic chk_above_r;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			chk_dual_r <= 1'b0;
			chk_pos_r <= '0;
			chk_zone_r <= 2'h0;
			chk_single_r <= 1'b0;
			chk_ch_r <= '0;
			chk_above_r <= 1'b0;
		end else begin
			chk_dual_r <= adc_sample_valid_i && is_dual_ch;
			chk_pos_r <= dual_pos;
			chk_zone_r <= dual_zone;
			chk_single_r <= adc_sample_valid_i && is_single_ch;
			chk_ch_r <= adc_channel_i;
			chk_above_r <= single_above;
		end
	end

	a_comp_follows: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(comp_sample_valid_i != '0) |=>
			((comp_input_state_r & $past(comp_sample_valid_i))
			== ($past(comp_above_i) & $past(comp_sample_valid_i))))
		else $error("comparator bit did not take the sampled level");

	a_comp_holds: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		##1 ((comp_input_state_r & ~$past(comp_sample_valid_i))
			== ($past(comp_input_state_r) & ~$past(comp_sample_valid_i))))
		else $error("comparator bit changed without a sample");

	a_write_ignored: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(wr_en_i && !adc_sample_valid_i && (comp_sample_valid_i == '0)) |=>
			$stable(comp_input_state_r) && $stable(adc_input_state_low_r))
		else $error("status register changed on a host write");

	a_single_update: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		chk_single_r |-> (adc_input_state_low_r[chk_ch_r] == chk_above_r))
		else $error("single threshold bit wrong after sample");

	a_dual_update: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		chk_dual_r |-> (adc_input_state_low_r[chk_pos_r +: 2] == chk_zone_r))
		else $error("dual threshold field wrong after sample");

	a_dual_range: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(adc_sample_valid_i && is_dual_ch) |->
			(dual_pos >= 5'h0C) && (dual_pos <= 5'h16) && !dual_pos[0])
		else $error("dual threshold field outside bits 23 to 12");

	a_no_code_three: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(adc_input_state_low_r[13:12] != 2'h3) && (adc_input_state_low_r[15:14] != 2'h3)
		&& (adc_input_state_low_r[17:16] != 2'h3) && (adc_input_state_low_r[19:18] != 2'h3)
		&& (adc_input_state_low_r[21:20] != 2'h3) && (adc_input_state_low_r[23:22] != 2'h3))
		else $error("unused field code 3 appeared");

	a_zone_order: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(adc_thr_low_i <= adc_thr_high_i) |->
			((dual_zone == switch_status_pkg::ZONE_ABOVE_HIGH) == (adc_value_i >= adc_thr_high_i))
			&& ((dual_zone == switch_status_pkg::ZONE_BELOW_LOW) == (adc_value_i < adc_thr_low_i)))
		else $error("zone code disagrees with thresholds");

	a_read_comp: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(rd_en_i && (addr_i == 8'h05)) |=> rd_valid_o && (rd_data_o == $past(comp_input_state_r)))
		else $error("comparator register read returned wrong data");

	a_read_adc: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(rd_en_i && (addr_i == 8'h06)) |=> rd_valid_o && (rd_data_o == $past(adc_input_state_low_r)))
		else $error("ADC register read returned wrong data");

	a_read_unmapped: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(rd_en_i && (addr_i != 8'h05) && (addr_i != 8'h06)) |=> rd_valid_o && (rd_data_o == '0))
		else $error("unmapped offset did not read zero");

	a_reset_clear: assert property (
		@(posedge clk_sys_i)
		!rst_n_i |=> (comp_input_state_r == '0) && (adc_input_state_low_r == '0) && !rd_valid_o)
		else $error("status not cleared by reset");

	c_comp_read: cover property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		comp_sample_valid_i[0] && comp_above_i[0] ##1 rd_en_i && (addr_i == 8'h05));

	c_dual_between: cover property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		adc_sample_valid_i && is_dual_ch && (dual_zone == switch_status_pkg::ZONE_BETWEEN));

	c_dual_high: cover property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		adc_sample_valid_i && (adc_channel_i == 5'h11)
		&& (dual_zone == switch_status_pkg::ZONE_ABOVE_HIGH));

	c_write_attempt: cover property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		wr_en_i && (addr_i == 8'h06) ##1 rd_en_i && (addr_i == 8'h06));

endmodule : switch_input_status_regs

`default_nettype wire

/* File: verif/host_model.sv */
// Host side of the register access port: issues single reads and writes.
// Assumes the bank samples strobes on the rising edge of clk_sys_i.
`include "switch_input_status_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module host_model (
	// Clock
	input wire logic clk_sys_i,
	// Register access toward the bank
	output logic rd_en_o,
	output logic wr_en_o,
	output logic [`SIS_ADDR_W-1:0] addr_o,
	output logic [`SIS_DATA_W-1:0] wr_data_o
);
	initial begin
		rd_en_o = 1'b0;
		wr_en_o = 1'b0;
		addr_o = 8'hFF;
		wr_data_o = 24'h000000;
	end

	// Released lines show the inverse of the last value
	task automatic read(input logic [`SIS_ADDR_W-1:0] a);
		@(posedge clk_sys_i);
		rd_en_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_sys_i);
		rd_en_o <= 1'b0;
		addr_o <= ~a;
	endtask : read

	// Writes are offered to show that status contents cannot be altered
	task automatic write(input logic [`SIS_ADDR_W-1:0] a, input logic [`SIS_DATA_W-1:0] d);
		@(posedge clk_sys_i);
		wr_en_o <= 1'b1;
		addr_o <= a;
		wr_data_o <= d;
		@(posedge clk_sys_i);
		wr_en_o <= 1'b0;
		addr_o <= ~a;
		wr_data_o <= ~d;
	endtask : write
endmodule : host_model
`default_nettype wire

/* File: verif/switch_input_status_regs_tb.sv */
// Self-checking bench of the switch input status bank.
// Assumes the host model drives the register port; samples come from here.
`include "switch_input_status_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module switch_input_status_regs_tb;
	localparam logic [9:0] THR_S = 10'h0C8;
	localparam logic [9:0] THR_L = 10'h064;
	localparam logic [9:0] THR_H = 10'h12C;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	wire logic rd_en, wr_en;
	wire logic [7:0] addr;
	wire logic [23:0] wr_data;
	logic [23:0] rd_data_o, comp_state_o, adc_state_o;
	logic rd_valid_o;
	logic [23:0] cvalid = 24'h000000;
	logic [23:0] cabove = 24'h000000;
	logic avalid = 1'b0;
	logic [4:0] ach = 5'h00;
	logic [9:0] aval = 10'h000;
	logic [23:0] comp_m = 24'h000000;
	logic [23:0] adc_m = 24'h000000;
	logic [15:0] seed = 16'h0012;
	logic [23:0] exp_q[$];
	int fail_count = 0;
	int n_checks = 0;

	always #5 clk_sys_i = ~clk_sys_i;

	host_model host (.clk_sys_i(clk_sys_i), .rd_en_o(rd_en), .wr_en_o(wr_en),
		.addr_o(addr), .wr_data_o(wr_data));

	switch_input_status_regs #(.ADC_W(10)) DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.rd_en_i(rd_en), .wr_en_i(wr_en), .addr_i(addr), .wr_data_i(wr_data),
		.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .comp_sample_valid_i(cvalid),
		.comp_above_i(cabove), .adc_sample_valid_i(avalid), .adc_channel_i(ach),
		.adc_value_i(aval), .adc_thr_single_i(THR_S), .adc_thr_low_i(THR_L),
		.adc_thr_high_i(THR_H), .comp_state_o(comp_state_o), .adc_state_o(adc_state_o));

	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr_next

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report;
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic rd(input logic [7:0] a, input logic [23:0] e);
		exp_q.push_back(e);
		host.read(a);
	endtask : rd

	task automatic comp(input logic [23:0] m, input logic [23:0] v);
		@(posedge clk_sys_i);
		cvalid <= m;
		cabove <= v;
		@(posedge clk_sys_i);
		cvalid <= 24'h000000;
		comp_m = (comp_m & ~m) | (v & m);
		#1 check(comp_state_o, comp_m);
	endtask : comp

	task automatic adc(input int ch, input logic [9:0] v);
		@(posedge clk_sys_i);
		avalid <= 1'b1;
		ach <= 5'(ch);
		aval <= v;
		@(posedge clk_sys_i);
		avalid <= 1'b0;
		if (ch < 12) adc_m[ch] = (v > THR_S);
		else if (ch < 18) adc_m[2*ch-12 +: 2] = (v >= THR_H) ? 2'h2 : (v >= THR_L) ? 2'h1 : 2'h0;
		#1 check(adc_state_o, adc_m);
	endtask : adc

	// Scoreboard on read answers, sampled mid-cycle where the answer has settled
	always @(negedge clk_sys_i) begin
		if (rd_valid_o === 1'b1) begin
			if (exp_q.size() == 0) check(rd_data_o, 24'hXXXXXX);
			else check(rd_data_o, exp_q.pop_front());
		end
	end

	initial begin
		#200000;
		fail_count++;
		final_report();
	end

	initial begin
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd(`SIS_OFF_COMP_STATE, `SIS_RST_COMP_STATE);
		rd(`SIS_OFF_ADC_STATE_LOW, `SIS_RST_ADC_STATE_LOW);
		for (int k = 0; k < 6; k++) begin
			seed = lfsr_next(seed);
			comp(24'(seed) ^ 24'hA5A5A5, {seed[7:0], seed});
		end
		comp(24'h000008, 24'hFFFFFF);
		for (int ch = 0; ch < 19; ch++) begin
			seed = lfsr_next(seed);
			adc(ch, seed[9:0] % 10'h190);
		end
		adc(0, THR_S);
		adc(1, THR_S + 10'h001);
		adc(12, THR_L);
		adc(13, THR_H);
		adc(14, THR_L - 10'h001);
		adc(15, THR_H - 10'h001);
		host.write(`SIS_OFF_COMP_STATE, ~comp_m);
		host.write(`SIS_OFF_ADC_STATE_LOW, ~adc_m);
		rd(`SIS_OFF_COMP_STATE, comp_m);
		rd(`SIS_OFF_ADC_STATE_LOW, adc_m);
		rd(8'h07, 24'h000000);
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		comp_m = 24'h000000;
		adc_m = 24'h000000;
		rd(`SIS_OFF_COMP_STATE, comp_m);
		rd(`SIS_OFF_ADC_STATE_LOW, adc_m);
		repeat (3) @(posedge clk_sys_i);
		check(24'(exp_q.size()), 24'h000000);
		final_report();
	end
endmodule : switch_input_status_regs_tb
`default_nettype wire
